// file: common/mem_ctrl_pkg.sv
package mem_ctrl_pkg;
  localparam int DATA_W      = 16;
  localparam int ADDR_W      = 18;
  localparam int WORD_IDX_W  = 14;
  localparam int MOD_MAX     = 4;
  localparam int MOD_SEL_W   = 2;
  localparam int BASE_W      = ADDR_W - WORD_IDX_W - 1;
  localparam logic [1:0] CYC_READ       = 2'h0;
  localparam logic [1:0] CYC_READ_PAUSE = 2'h1;
  localparam logic [1:0] CYC_WORD_WRITE = 2'h2;
  localparam logic [1:0] CYC_BYTE_WRITE = 2'h3;
  localparam int CYC_WRITE_BIT = 1;
  localparam int BYTE_SEL_BIT  = 0;
  localparam int ACCESS_NS     = 8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int ACCESS_CYC    =
    (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
endpackage

// file: core/matrix_array.sv
`timescale 1ns/100ps
`default_nettype none
// Word storage with byte enables and parity per byte
module matrix_array
  import mem_ctrl_pkg::*;
#(
  parameter int DEPTH = 1 << WORD_IDX_W
)
(
  input  wire logic              clk,
  input  wire logic [WORD_IDX_W-1:0] addr,
  input  wire logic              wrEn,
  input  wire logic [1:0]        byteEn,
  input  wire logic [DATA_W-1:0] wrData,
  output logic      [DATA_W-1:0] rdData,
  output logic                   rdParErr
);
  initial
  begin
    if (DEPTH > (1 << WORD_IDX_W) || DEPTH < 1)
      $error("matrix_array depth out of range");
  end
  logic [DATA_W-1:0] mem [DEPTH];
  logic [1:0]        par [DEPTH];
  logic [1:0]        rdPar;
  // Unwritten words read as parity errors in hardware; no init
  always_ff @(posedge clk)
  begin
    if (wrEn && byteEn[0])
    begin
      mem[addr][7:0] <= wrData[7:0];
      par[addr][0]   <= ^wrData[7:0];
    end
    if (wrEn && byteEn[1])
    begin
      mem[addr][15:8] <= wrData[15:8];
      par[addr][1]    <= ^wrData[15:8];
    end
    rdData <= mem[addr];
    rdPar  <= par[addr];
  end
  always_comb
  begin
    rdParErr = (^rdData[7:0] != rdPar[0]) || (^rdData[15:8] != rdPar[1]);
  end
endmodule // matrix_array
`default_nettype wire

// file: core/semiconductor_memory_access_control.sv
`timescale 1ns/100ps
`default_nettype none
module semiconductor_memory_access_control
  import mem_ctrl_pkg::*;
#(
  parameter int MOD_COUNT = MOD_MAX,
  parameter int MOD_WORDS = 4096,
  parameter logic [BASE_W-1:0] BASE_SEL = 3'h0
)
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [5:0]        low_address_bits,
  input  wire logic [11:0]       high_address_bits,
  input  wire logic [DATA_W-1:0] write_data_lines,
  input  wire logic              bus_start_request,
  input  wire logic              cycle_commit,
  input  wire logic              cycle_type_bit0,
  input  wire logic              cycle_type_bit1,
  input  wire logic              prefetch_abort,
  input  wire logic              parity_error_ack,
  input  wire logic [ADDR_W-1:0] sysAddr,
  input  wire logic [DATA_W-1:0] sysWrData,
  input  wire logic [1:0]        sysCycleType,
  input  wire logic              sysReq,
  output logic      [DATA_W-1:0] read_data_lines,
  output logic                   address_hit_ack,
  output logic                   completion_strobe,
  output logic                   parity_error_flag,
  output logic      [DATA_W-1:0] sysRdData,
  output logic                   sysDone,
  output logic                   sysParErr,
  output logic                   pauseHeld
);
  initial
  begin
    if (MOD_COUNT < 1 || MOD_COUNT > MOD_MAX)
      $error("module count out of range");
    if (MOD_COUNT * MOD_WORDS > (1 << WORD_IDX_W))
      $error("capacity beyond control range");
  end
  localparam int DEPTH = MOD_COUNT * MOD_WORDS;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_ACCESS = 5'b00010,
    ST_COMMIT = 5'b00100,
    ST_DONE   = 5'b01000,
    ST_PAUSE  = 5'b10000
  } state_t;

  function automatic logic inRange(input logic [ADDR_W-1:0] a);
    inRange = (a[ADDR_W-1 -: BASE_W] == BASE_SEL) &&
              (int'(a[WORD_IDX_W:1]) < DEPTH);
  endfunction

  function automatic logic [1:0] laneEn(input logic [1:0] ct,
                                        input logic bsel);
    if (ct == CYC_BYTE_WRITE)
      laneEn = bsel ? 2'h2 : 2'h1;
    else
      laneEn = 2'h3;
  endfunction

  // Pins from the processor cross into this clock
  logic [17:0] fAddrS1, fAddrS2;
  logic [15:0] fDataS1, fDataS2;
  logic [5:0]  ctlS1, ctlS2;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fAddrS1 <= '0;
      fAddrS2 <= '0;
      fDataS1 <= '0;
      fDataS2 <= '0;
      ctlS1   <= '0;
      ctlS2   <= '0;
    end
    else
    begin
      fAddrS1 <= {high_address_bits, low_address_bits};
      fAddrS2 <= fAddrS1;
      fDataS1 <= write_data_lines;
      fDataS2 <= fDataS1;
      ctlS1   <= {bus_start_request, cycle_commit, cycle_type_bit1,
                  cycle_type_bit0, prefetch_abort, parity_error_ack};
      ctlS2   <= ctlS1;
    end
  end
  logic fStart, fCommit, fAbort, fAck;
  logic [1:0] fType;
  assign fStart  = ctlS2[5];
  assign fCommit = ctlS2[4];
  assign fType   = ctlS2[3:2];
  assign fAbort  = ctlS2[1];
  assign fAck    = ctlS2[0];

  state_t             state_ff;
  logic               srcSys_ff;
  logic [1:0]         type_ff;
  logic [ADDR_W-1:0]  addr_ff;
  logic [DATA_W-1:0]  wdata_ff;
  logic [2:0]         cnt_ff;
  logic               fHit;
  logic               sysPend_ff;
  logic               mWr;
  logic [DATA_W-1:0]  mRd;
  logic               mParErr;

  assign fHit = inRange(fAddrS2);

  // Start is level; re-arm only after it drops, else a held
  // start seen through the sync delay would restart the cycle
  logic fArm_ff;
  logic fTake;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fArm_ff <= 1'b1;
    else if (fTake)
      fArm_ff <= 1'b0;
    else if (!fStart)
      fArm_ff <= 1'b1;
  end
  assign fTake = fStart && fArm_ff && fHit &&
                 (state_ff == ST_IDLE ||
                  (state_ff == ST_PAUSE &&
                   (fType[CYC_WRITE_BIT] || !srcSys_ff)));

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      address_hit_ack <= 1'b0;
    else
      address_hit_ack <= fHit;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sysPend_ff <= 1'b0;
    else if (sysDone)
      sysPend_ff <= 1'b0;
    else if (sysReq && inRange(sysAddr))
      sysPend_ff <= 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff  <= ST_IDLE;
      srcSys_ff <= 1'b0;
      type_ff   <= CYC_READ;
      addr_ff   <= '0;
      wdata_ff  <= DATA_RST;
      cnt_ff    <= '0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE, ST_PAUSE:
        begin
          if (fTake)
          begin
            state_ff  <= ST_ACCESS;
            srcSys_ff <= 1'b0;
            type_ff   <= fType;
            addr_ff   <= fAddrS2;
            wdata_ff  <= fDataS2;
            cnt_ff    <= 3'(ACCESS_CYC);
          end
          else if (sysPend_ff && !sysDone && (state_ff == ST_IDLE ||
                   (srcSys_ff && sysCycleType[CYC_WRITE_BIT])))
          begin
            state_ff  <= ST_ACCESS;
            srcSys_ff <= 1'b1;
            type_ff   <= sysCycleType;
            addr_ff   <= sysAddr;
            wdata_ff  <= sysWrData;
            cnt_ff    <= 3'(ACCESS_CYC);
          end
        end
        ST_ACCESS:
        begin
          if (!srcSys_ff && fAbort)
            state_ff <= ST_IDLE;
          else if (cnt_ff > 3'h1)
            cnt_ff <= cnt_ff - 3'h1;
          else
            state_ff <= srcSys_ff ? ST_DONE : ST_COMMIT;
        end
        ST_COMMIT:
        begin
          if (fAbort)
            state_ff <= ST_IDLE;
          else if (fCommit)
            state_ff <= ST_DONE;
        end
        ST_DONE:
        begin
          if (type_ff == CYC_READ_PAUSE && !mParErr)
            state_ff <= ST_PAUSE;
          else
            state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  assign mWr = (state_ff == ST_DONE) && type_ff[CYC_WRITE_BIT];

  matrix_array #(
    .DEPTH(DEPTH)
  ) u_matrix (
    .clk      (clk),
    .addr     (addr_ff[WORD_IDX_W:1]),
    .wrEn     (mWr),
    .byteEn   (laneEn(type_ff, addr_ff[BYTE_SEL_BIT])),
    .wrData   (wdata_ff),
    .rdData   (mRd),
    .rdParErr (mParErr)
  );

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      completion_strobe <= 1'b0;
      sysDone           <= 1'b0;
      pauseHeld         <= 1'b0;
    end
    else
    begin
      completion_strobe <= (state_ff == ST_DONE) && !srcSys_ff;
      sysDone           <= (state_ff == ST_DONE) && srcSys_ff;
      pauseHeld         <= (state_ff == ST_PAUSE);
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      read_data_lines <= DATA_RST;
      sysRdData       <= DATA_RST;
      sysParErr       <= 1'b0;
    end
    else if (state_ff == ST_DONE && !type_ff[CYC_WRITE_BIT])
    begin
      if (srcSys_ff)
      begin
        sysRdData <= mRd;
        sysParErr <= mParErr;
      end
      else
        read_data_lines <= mRd;
    end
  end

  // parity flag; set wins over ack
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      parity_error_flag <= 1'b0;
    else if (state_ff == ST_DONE && !srcSys_ff &&
             !type_ff[CYC_WRITE_BIT] && mParErr)
      parity_error_flag <= 1'b1;
    else if (fAck)
      parity_error_flag <= 1'b0;
  end
endmodule // semiconductor_memory_access_control
`default_nettype wire

// file: bench/mem_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mem_ctrl_monitor
  import mem_ctrl_pkg::*;
#(
  parameter logic [BASE_W-1:0] BASE_SEL = 3'h0
)
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [11:0]       high_address_bits,
  input wire logic              bus_start_request,
  input wire logic              cycle_commit,
  input wire logic              prefetch_abort,
  input wire logic              parity_error_ack,
  input wire logic [DATA_W-1:0] read_data_lines,
  input wire logic              address_hit_ack,
  input wire logic              completion_strobe,
  input wire logic              parity_error_flag,
  input wire logic              pauseHeld
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Covers two sync stages plus the decode register
  sequence addrSteady;
    $stable(high_address_bits)[*4];
  endsequence
  sequence flagUnanswered;
    (parity_error_flag && !parity_error_ack)[*3];
  endsequence
  AST_HIT_RANGE: assert property (
    addrSteady |->
      address_hit_ack == (high_address_bits[11:9] == BASE_SEL))
    else $error("hit wrong");
  AST_STROBE_ONE: assert property (
    completion_strobe |=> !completion_strobe)
    else $error("strobe too long");
  AST_STROBE_COMMIT: assert property (
    completion_strobe |-> $past(cycle_commit, 3))
    else $error("strobe without commit");
  AST_STROBE_START: assert property (
    completion_strobe |-> $past(bus_start_request, 4))
    else $error("strobe without start");
  AST_RDATA_HOLD: assert property (
    !$stable(read_data_lines) |-> completion_strobe)
    else $error("read data moved");
  AST_FLAG_STICKY: assert property (
    flagUnanswered |=> parity_error_flag)
    else $error("flag lost");
  AST_ABORT: assert property (
    prefetch_abort[*5] |-> !completion_strobe)
    else $error("strobe after abort");
  AST_PAUSE_ENTRY: assert property (
    $rose(pauseHeld) |-> completion_strobe || $past(completion_strobe))
    else $error("pause without read");
endmodule // mem_ctrl_monitor
`default_nettype wire

// file: bench/cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_model
  import mem_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] rdData,
  input  wire logic              strobe,
  input  wire logic              perf,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wrData,
  output logic                   start,
  output logic                   commit,
  output logic      [1:0]        cyc,
  output logic                   abort,
  output logic                   perfAck
);
  initial
  begin
    {addr, wrData, start, commit, cyc, abort, perfAck} = '0;
  end
  task automatic access(input logic [1:0] t, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
    output logic seen);
    seen = 1'b0;
    addr = a;
    wrData = d;
    cyc = t;
    start = 1'b1;
    repeat (2) @(posedge clk);
    #1 commit = 1'b1;
    for (int i = 0; i < 30 && seen !== 1'b1; i++)
    begin
      @(posedge clk);
      #1 seen = strobe;
    end
    q = rdData;
    perfAck = perf;
    commit = 1'b0;
    start = 1'b0;
    // Released lines must not keep the last value
    addr = ~a;
    wrData = ~d;
    repeat (3) @(posedge clk);
    #1 perfAck = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic drop(input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic seen);
    seen = 1'b0;
    addr = a;
    wrData = d;
    cyc = CYC_WORD_WRITE;
    start = 1'b1;
    @(posedge clk);
    #1 abort = 1'b1;
    @(posedge clk);
    #1 commit = 1'b1;
    repeat (8)
    begin
      @(posedge clk);
      #1 seen = seen | strobe;
    end
    {start, commit} = 2'h0;
    addr = ~a;
    wrData = ~d;
    repeat (3) @(posedge clk);
    #1 abort = 1'b0;
  endtask
endmodule // cpu_model
`default_nettype wire

// file: bench/tb_semiconductor_memory_access_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_semiconductor_memory_access_control
  import mem_ctrl_pkg::*;
;
  logic              clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] addr, sysAddr;
  logic [DATA_W-1:0] wrData, rdData, sysRdData, sysWrData;
  logic [1:0]        cyc, sysCycleType;
  logic              start, commit, abort, perfAck, sysReq;
  logic              hit, strobe, perf, sysDone, pauseHeld;
  int                fails, n_compared;

  semiconductor_memory_access_control semiconductor_memory_access_control_inst (
    .clk(clk), .sys_rst(sys_rst), .low_address_bits(addr[5:0]),
    .high_address_bits(addr[17:6]), .write_data_lines(wrData),
    .bus_start_request(start), .cycle_commit(commit),
    .cycle_type_bit0(cyc[0]), .cycle_type_bit1(cyc[1]),
    .prefetch_abort(abort), .parity_error_ack(perfAck),
    .sysAddr(sysAddr), .sysWrData(sysWrData),
    .sysCycleType(sysCycleType), .sysReq(sysReq),
    .read_data_lines(rdData), .address_hit_ack(hit),
    .completion_strobe(strobe), .parity_error_flag(perf),
    .sysRdData(sysRdData), .sysDone(sysDone), .sysParErr(),
    .pauseHeld(pauseHeld));
  cpu_model cpu_model_inst (
    .clk(clk), .rdData(rdData), .strobe(strobe), .perf(perf),
    .addr(addr), .wrData(wrData), .start(start), .commit(commit),
    .cyc(cyc), .abort(abort), .perfAck(perfAck));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [DATA_W-1:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] t, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    logic              s;
    cpu_model_inst.access(t, a, d, q, s);
    chk({15'h0000, s}, 16'h0001);
  endtask
  task automatic rd(input logic [1:0] t, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] q;
    logic              s;
    cpu_model_inst.access(t, a, 16'h0000, q, s);
    chk(q, exp);
  endtask
  // Single-cycle request, so a held level cannot queue a repeat
  task automatic sys(input logic [1:0] t, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    {sysCycleType, sysAddr, sysWrData, sysReq} = {t, a, d, 1'b1};
    @(posedge clk);
    #1 sysReq = 1'b0;
    for (int i = 0; i < 30 && sysDone !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    q = sysRdData;
    chk({15'h0000, sysDone}, 16'h0001);
  endtask

  task automatic t_main();
    logic [DATA_W-1:0] q;
    logic              s;
    wr(CYC_WORD_WRITE, 18'h00010, 16'hA5C3);
    wr(CYC_WORD_WRITE, 18'h00012, 16'h5A3C);
    rd(CYC_READ, 18'h00010, 16'hA5C3);
    rd(CYC_READ, 18'h00010, 16'hA5C3);
    wr(CYC_WORD_WRITE, 18'h00020, 16'h1234);
    wr(CYC_BYTE_WRITE, 18'h00021, 16'hAB55);
    rd(CYC_READ, 18'h00020, 16'hAB34);
    wr(CYC_BYTE_WRITE, 18'h00020, 16'h66CD);
    rd(CYC_READ, 18'h00020, 16'hABCD);
    $display("word and byte done");
    wr(CYC_WORD_WRITE, 18'h00030, 16'h5A5A);
    rd(CYC_READ_PAUSE, 18'h00030, 16'h5A5A);
    chk({15'h0000, pauseHeld}, 16'h0001);
    wr(CYC_BYTE_WRITE, 18'h00030, 16'hFFA5);
    chk({15'h0000, pauseHeld}, 16'h0000);
    rd(CYC_READ, 18'h00030, 16'h5AA5);
    $display("pause done");
    cpu_model_inst.access(CYC_WORD_WRITE, 18'h08010, 16'hFFFF, q, s);
    chk({15'h0000, s}, 16'h0000);
    chk({15'h0000, hit}, 16'h0000);
    cpu_model_inst.drop(18'h00010, 16'h0F0F, s);
    chk({15'h0000, s}, 16'h0000);
    rd(CYC_READ, 18'h00010, 16'hA5C3);
    $display("range and abort done");
    sys(CYC_WORD_WRITE, 18'h00050, 16'hC3C3, q);
    rd(CYC_READ, 18'h00050, 16'hC3C3);
    sys(CYC_READ, 18'h00012, 16'h0000, q);
    chk(q, 16'h5A3C);
    $display("system port done");
  endtask

  task automatic end_of_test();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #30000;
    fails++;
    end_of_test();
  end

  initial
  begin
    {fails, n_compared} = '0;
    {sysAddr, sysWrData, sysCycleType, sysReq} = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(rdData, 16'h0000);
    t_main();
    end_of_test();
  end
endmodule // tb_semiconductor_memory_access_control

bind semiconductor_memory_access_control mem_ctrl_monitor #(
  .BASE_SEL(BASE_SEL)
) mem_ctrl_monitor_inst (
  .clk(clk), .sys_rst(sys_rst), .high_address_bits(high_address_bits),
  .bus_start_request(bus_start_request), .cycle_commit(cycle_commit),
  .prefetch_abort(prefetch_abort), .parity_error_ack(parity_error_ack),
  .read_data_lines(read_data_lines), .address_hit_ack(address_hit_ack),
  .completion_strobe(completion_strobe),
  .parity_error_flag(parity_error_flag), .pauseHeld(pauseHeld));
`default_nettype wire
